// ---- lps_rx_model.sv ----
// Behavioural panel receiver: frames four data lanes on the clock lane.
// Assumes lane bits are sampled on the transmitter bit clock.
`timescale 1ns/100ps
module lps_rx_model (
  input  wire logic       clk,
  input  wire logic [4:0] lane_bit,
  input  wire logic       lanes_on,
  input  wire logic       clock_on,
  output lps_pkg::lps_pixel_t rx_word,
  output logic            rx_valid
);
  // --------
  // Framing
  // --------
  logic [6:0] sh [5];
  // Lane 3 stays wired so that full words can be compared.
  always @(posedge clk) begin
    for (int k = 0; k < 5; k++) begin
      sh[k] <= {lane_bit[k], sh[k][6:1]};
    end
  end
  // A pair in high impedance carries nothing, so framing needs both enables.
  assign rx_valid = lanes_on && clock_on && (sh[4] == lps_pkg::CLOCK_PATTERN);
  assign rx_word  = {sh[3], sh[2], sh[1], sh[0]};
endmodule : lps_rx_model

// ---- lps_serializer.sv ----
// Pixel link transmitter: captures 28 parallel pixel bits and sends them over
// four serial lanes plus a forwarded clock lane.
// Assumes clk is the locked seven-times bit clock and pixel_clock_in runs at
// one seventh of it; the lane drivers resolve pos/neg/oe into the pad.
`timescale 1ns/100ps

module lps_serializer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        pixel_clock_in,
  input  wire logic [27:0] parallel_pixel_bits,
  input  wire logic        capture_edge_select,
  input  wire logic        power_down_n,
  output logic             lane0_pos,
  output logic             lane0_neg,
  output logic             lane1_pos,
  output logic             lane1_neg,
  output logic             lane2_pos,
  output logic             lane2_neg,
  output logic             lane3_pos,
  output logic             lane3_neg,
  output logic             data_lanes_oe,
  output logic             forwarded_clock_pos,
  output logic             forwarded_clock_neg,
  output logic             forwarded_clock_oe
);
  // ----------------------------------------------------------------------
  // Pixel clock domain: capture
  // ----------------------------------------------------------------------
  logic [1:0]       pd_sync_px;
  logic [1:0]       sel_sync_px;
  logic [27:0]      fall_hold;
  lps_pkg::lps_pixel_t bank [2];
  logic             wr_tog;
  logic             px_run;
  logic             px_sel;

  assign px_run = pd_sync_px[1];
  assign px_sel = sel_sync_px[1];

  always_ff @(posedge pixel_clock_in or posedge rst) begin
    if (rst) begin
      pd_sync_px  <= 2'h0;
      sel_sync_px <= 2'h0;
    end else begin
      pd_sync_px  <= {pd_sync_px[0], power_down_n};
      sel_sync_px <= {sel_sync_px[0], capture_edge_select};
    end
  end

  // Falling-edge sample is moved to the rising edge half a period later.
  always_ff @(negedge pixel_clock_in or posedge rst) begin
    if (rst) begin
      fall_hold <= 28'h0;
    end else if (!px_run) begin
      fall_hold <= 28'h0;
    end else begin
      fall_hold <= parallel_pixel_bits;
    end
  end

  // Two banks alternate so the bit-clock side reads the bank last written, which stays
  // unchanged for two pixel periods; the switch waits for the two-stage toggle sync.
  always_ff @(posedge pixel_clock_in or posedge rst) begin
    if (rst) begin
      bank[0] <= '0;
      bank[1] <= '0;
      wr_tog  <= 1'b0;
    end else if (!px_run) begin
      bank[0] <= '0;
      bank[1] <= '0;
      wr_tog  <= 1'b0;
    end else begin
      bank[wr_tog] <= px_sel ? parallel_pixel_bits : fall_hold;
      wr_tog       <= ~wr_tog;
    end
  end

  // ----------------------------------------------------------------------
  // Bit clock domain: framing and shifting
  // ----------------------------------------------------------------------
  logic [1:0]         pd_sync;
  logic [1:0]         tog_sync;
  lps_pkg::lps_state_t state;
  lps_pkg::lps_state_t next_state;
  logic [2:0]         phase;
  logic               frame_load;
  logic               running;
  logic               primed;
  lps_pkg::lps_pixel_t rd_word;
  logic [6:0]         slice [lps_pkg::DATA_LANES + 1];
  logic [4:0]         serial;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pd_sync  <= 2'h0;
      tog_sync <= 2'h0;
    end else begin
      pd_sync  <= {pd_sync[0], power_down_n};
      tog_sync <= {tog_sync[0], wr_tog};
    end
  end

  always_comb begin
    case (state)
      lps_pkg::LPS_OFF: next_state = pd_sync[1] ? lps_pkg::LPS_RUN : lps_pkg::LPS_OFF;
      lps_pkg::LPS_RUN: next_state = pd_sync[1] ? lps_pkg::LPS_RUN : lps_pkg::LPS_OFF;
      default:          next_state = lps_pkg::LPS_OFF;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= lps_pkg::LPS_OFF;
    end else begin
      state <= next_state;
    end
  end

  assign running = (state == lps_pkg::LPS_RUN);

  // The phase counter is the internal clock; it stands at zero while off.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= lps_pkg::PHASE_RESET;
    end else if (!running) begin
      phase <= lps_pkg::PHASE_RESET;
    end else if (phase == lps_pkg::PHASE_LAST) begin
      phase <= lps_pkg::PHASE_RESET;
    end else begin
      phase <= phase + 3'h1;
    end
  end

  assign frame_load = running && (phase == lps_pkg::PHASE_RESET);
  // The bank last written is the one opposite the synchronised toggle.
  assign rd_word    = bank[~tog_sync[1]];

  assign slice[0] = rd_word.lane0;
  assign slice[1] = rd_word.lane1;
  assign slice[2] = rd_word.lane2;
  assign slice[3] = rd_word.lane3;
  assign slice[4] = lps_pkg::CLOCK_PATTERN;

  genvar g;
  generate
    for (g = 0; g <= lps_pkg::DATA_LANES; g++) begin : g_lane
      lps_shift_lane #(
        .W (lps_pkg::LANE_BITS)
      ) u_lane (
        .clk        (clk),
        .rst        (rst),
        .clear      (!running),
        .load       (frame_load),
        .load_bits  (slice[g]),
        .serial_bit (serial[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Frame priming
  // ----------------------------------------------------------------------
  // The shifters hold zeros until their first load, so the pads stay off for
  // one more cycle; otherwise the clock lane would open with a stray low bit
  // and the panel would see one short clock period after every power-up.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      primed <= 1'b0;
    end else if (!running) begin
      primed <= 1'b0;
    end else if (frame_load) begin
      primed <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Output drivers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {lane0_pos, lane1_pos, lane2_pos, lane3_pos} <= 4'h0;
      {lane0_neg, lane1_neg, lane2_neg, lane3_neg} <= 4'h0;
      data_lanes_oe <= 1'b0;
    end else if (!running || !primed) begin
      // Both pad members sit low here; the low enable makes the pair high impedance.
      {lane0_pos, lane1_pos, lane2_pos, lane3_pos} <= 4'h0;
      {lane0_neg, lane1_neg, lane2_neg, lane3_neg} <= 4'h0;
      data_lanes_oe <= 1'b0;
    end else begin
      {lane3_pos, lane2_pos, lane1_pos, lane0_pos} <= serial[3:0];
      {lane3_neg, lane2_neg, lane1_neg, lane0_neg} <= ~serial[3:0];
      data_lanes_oe <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      forwarded_clock_pos <= 1'b0;
      forwarded_clock_neg <= 1'b0;
      forwarded_clock_oe  <= 1'b0;
    end else if (!running || !primed) begin
      // The clock pair is released together with the data pairs.
      forwarded_clock_pos <= 1'b0;
      forwarded_clock_neg <= 1'b0;
      forwarded_clock_oe  <= 1'b0;
    end else begin
      forwarded_clock_pos <= serial[4];
      forwarded_clock_neg <= ~serial[4];
      forwarded_clock_oe  <= 1'b1;
    end
  end
endmodule : lps_serializer

// ---- lps_serializer_chk.sv ----
// Pin assertions for the pixel serializer, bound to its top module.
// Assumes the bit clock domain; power-down needs a few cycles to settle.
`timescale 1ns/100ps
module lps_serializer_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_down_n,
  input wire logic lane0_pos,
  input wire logic lane0_neg,
  input wire logic lane1_pos,
  input wire logic lane1_neg,
  input wire logic lane2_pos,
  input wire logic lane2_neg,
  input wire logic lane3_pos,
  input wire logic lane3_neg,
  input wire logic data_lanes_oe,
  input wire logic forwarded_clock_pos,
  input wire logic forwarded_clock_neg,
  input wire logic forwarded_clock_oe
);
  // ----------
  // Properties
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_lane_hiz: assert property ((!power_down_n) [*5] |-> !data_lanes_oe)
    else $error("data lanes driven in power-down");
  a_clock_hiz: assert property ((!power_down_n) [*5] |-> !forwarded_clock_oe)
    else $error("clock lane driven in power-down");
  a_run_on: assert property (power_down_n [*8] |-> data_lanes_oe && forwarded_clock_oe)
    else $error("lanes not driven while running");
  a_off_zero: assert property (!data_lanes_oe |->
    !(lane0_pos || lane0_neg || lane1_pos || lane1_neg || lane2_pos || lane2_neg || lane3_pos || lane3_neg))
    else $error("lane state not cleared while off");
  a_off_quiet: assert property ((!power_down_n) [*6] |=> $stable(forwarded_clock_pos) && !forwarded_clock_pos)
    else $error("clock lane toggles in power-down");
  a_lane_diff: assert property (data_lanes_oe |->
    lane0_neg != lane0_pos && lane1_neg != lane1_pos && lane2_neg != lane2_pos && lane3_neg != lane3_pos)
    else $error("data pair not complementary");
  a_clock_diff: assert property (forwarded_clock_oe |-> forwarded_clock_neg != forwarded_clock_pos)
    else $error("clock pair not complementary");
  a_clock_period: assert property (forwarded_clock_oe [*8] |-> forwarded_clock_pos == $past(forwarded_clock_pos, 7))
    else $error("clock lane period is not seven bits");
endmodule : lps_serializer_chk

bind lps_serializer lps_serializer_chk lps_serializer_chk_inst (
  .clk(clk), .rst(rst), .power_down_n(power_down_n), .lane0_pos(lane0_pos), .lane0_neg(lane0_neg),
  .lane1_pos(lane1_pos), .lane1_neg(lane1_neg), .lane2_pos(lane2_pos), .lane2_neg(lane2_neg),
  .lane3_pos(lane3_pos), .lane3_neg(lane3_neg), .data_lanes_oe(data_lanes_oe),
  .forwarded_clock_pos(forwarded_clock_pos), .forwarded_clock_neg(forwarded_clock_neg),
  .forwarded_clock_oe(forwarded_clock_oe)
);

// ---- lps_shift_lane.sv ----
// Package for the pixel serializer and the seven-bit lane shifter it uses.
// Assumes the shifter is clocked by the seven-times bit clock of the parent.
package lps_pkg;
  localparam int        LANE_BITS     = 7;
  localparam int        DATA_LANES    = 4;
  localparam int        PIXEL_BITS    = LANE_BITS * DATA_LANES;
  localparam int        SYNC_STAGES   = 2;
  localparam int        PHASE_W       = 3;
  localparam logic [2:0] PHASE_LAST   = 3'h6;
  localparam logic [2:0] PHASE_RESET  = 3'h0;
  localparam logic [6:0] CLOCK_PATTERN = 7'h63;
  localparam logic [6:0] SLICE_RESET  = 7'h00;

  typedef struct packed {
    logic [6:0] lane3;
    logic [6:0] lane2;
    logic [6:0] lane1;
    logic [6:0] lane0;
  } lps_pixel_t;

  typedef enum logic [0:0] {
    LPS_OFF,
    LPS_RUN
  } lps_state_t;
endpackage : lps_pkg

`timescale 1ns/100ps

module lps_shift_lane #(
  parameter int W = 7
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clear,
  input  wire logic         load,
  input  wire logic [W-1:0] load_bits,
  output logic              serial_bit
);
  logic [W-1:0] shreg;

  // A one-bit shifter could not hold a slice and shift it at the same time.
  if (W < 2) begin : g_bad_width
    $error("lps_shift_lane: W must be at least 2");
  end

  // Bits leave least significant first; a clear wins over load and shift.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shreg <= '0;
    end else if (clear) begin
      shreg <= '0;
    end else if (load) begin
      shreg <= load_bits;
    end else begin
      shreg <= {1'b0, shreg[W-1:1]};
    end
  end

  assign serial_bit = shreg[0];
endmodule : lps_shift_lane

// ---- testbench.sv ----
// Self-checking bench for the pixel serializer with a panel receiver model.
// Assumes a 25 ns bit clock and an unrelated 64 ns pixel clock.
`timescale 1ns/100ps
module testbench;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                pixel_clock_in = 1'b0;
  logic [27:0]         parallel_pixel_bits = 28'h0000000;
  logic                capture_edge_select = 1'b1;
  logic                power_down_n = 1'b1;
  logic [4:0]          lane_bit;
  logic                data_lanes_oe;
  logic                forwarded_clock_oe;
  logic                rx_valid;
  lps_pkg::lps_pixel_t rx_word;
  int                  n_mismatch = 0;
  int                  samples_checked = 0;
  always #12.5 clk = ~clk;
  // The odd start offset keeps every pixel clock edge off the bit clock edges,
  // so no capture ever races a stimulus change.
  initial begin
    #3.3;
    forever #32 pixel_clock_in = ~pixel_clock_in;
  end
  lps_serializer lps_serializer_inst (.clk(clk), .rst(rst), .pixel_clock_in(pixel_clock_in),
    .parallel_pixel_bits(parallel_pixel_bits), .capture_edge_select(capture_edge_select),
    .power_down_n(power_down_n), .lane0_pos(lane_bit[0]), .lane0_neg(), .lane1_pos(lane_bit[1]),
    .lane1_neg(), .lane2_pos(lane_bit[2]), .lane2_neg(), .lane3_pos(lane_bit[3]), .lane3_neg(),
    .data_lanes_oe(data_lanes_oe), .forwarded_clock_pos(lane_bit[4]), .forwarded_clock_neg(),
    .forwarded_clock_oe(forwarded_clock_oe));
  lps_rx_model lps_rx_model_inst (.clk(clk), .lane_bit(lane_bit), .lanes_on(data_lanes_oe),
    .clock_on(forwarded_clock_oe), .rx_word(rx_word), .rx_valid(rx_valid));
  // ---------
  // Scenarios
  // ---------
  task automatic results();
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  task automatic check(input logic [27:0] got, input logic [27:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  // Drives hi while the pixel clock is high and lo while it is low, so the word
  // that reaches the panel shows which pixel clock edge captured it.
  task automatic run_frames(input logic [27:0] hi, input logic [27:0] lo, input logic sel, input int n);
    int k = 0;
    for (int i = 0; i < 300 && k < n; i++) begin
      @(negedge clk);
      capture_edge_select = sel;
      parallel_pixel_bits = pixel_clock_in ? hi : lo;
      if (rx_valid === 1'b1) k++;
    end
    if (k < n) begin
      n_mismatch++;
      results();
    end
  endtask : run_frames
  task automatic t_rise();
    run_frames(28'h3C3C3C3, 28'hA5C3E1F, 1'b1, 6);
    check(rx_word, 28'hA5C3E1F);
  endtask : t_rise
  task automatic t_fall();
    run_frames(28'h5A3C1E0, 28'h0F0F0F0, 1'b0, 6);
    check(rx_word, 28'h5A3C1E0);
  endtask : t_fall
  task automatic t_colour18();
    run_frames(28'h7FFF3DD, 28'h7FFF3DD, 1'b1, 6);
    check(rx_word, 28'h7FFF3DD);
  endtask : t_colour18
  task automatic t_shutdown();
    int active = 0;
    @(negedge clk);
    power_down_n = 1'b0;
    parallel_pixel_bits = 28'h1234567;
    repeat (8) @(negedge clk);
    check(28'({data_lanes_oe, forwarded_clock_oe}), 28'h0000000);
    check(28'(lane_bit), 28'h0000000);
    repeat (30) begin
      @(negedge clk);
      if (lane_bit !== 5'h00 || rx_valid !== 1'b0) active++;
    end
    check(28'(active), 28'h0000000);
    power_down_n = 1'b1;
    run_frames(28'h1234567, 28'h1234567, 1'b1, 6);
    check(rx_word, 28'h1234567);
  endtask : t_shutdown
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_rise();
    t_fall();
    t_colour18();
    t_shutdown();
    results();
  end
endmodule : testbench
